/* File: logic/sdram_hold_port.v */
`timescale 1ns/10ps
`include "sdram_port_map.vh"
// Behaviour
// - Shared strobes act as column, write, row strobes
// - Read data returns three clocks after command
// - Issue write, activate, precharge, refresh, mode commands
// - Self refresh and clock enable wide only
// - Transfer strobe only when channel option enables
// - Transfer read does not capture data
// - Read latency field delays strobe zero-three cycles
// - Transfer write keeps data bus floating
// - Write latency field delays strobe zero-three cycles
// - Finish transactions, float, then acknowledge hold
// - Hold disable ignores hold requests
// - Release drives bus in 2-7 periods
// - Clock float bit tristates clock during hold
// - Hold floats memory bus outputs via bus_oe and mem_data_oe; extra_out_enable stays high
module sdram_hold_port #(
   parameter WIDE = 1,
   parameter DW = 64,
   parameter AW = 20
) (
   // Clock and reset
   input wire clock,
   input wire rst_n,
   // Command port from the transfer engine
   input wire cmd_valid,
   input wire [2:0] cmd_op,
   input wire [3:0] cmd_cs,
   input wire [AW-1:0] cmd_addr,
   input wire [DW-1:0] cmd_wdata,
   input wire [DW/8-1:0] cmd_be,
   input wire xfer_src_enable,
   input wire xfer_dst_enable,
   input wire self_exit,
   output reg cmd_ready,
   output reg [DW-1:0] rd_data,
   output reg rd_valid,
   // Control bits
   input wire [1:0] xfer_read_latency,
   input wire [1:0] xfer_write_latency,
   input wire hold_disable,
   input wire mem_clk_float_sel,
   // Memory clock
   output reg mem_clk_out,
   output reg mem_clk_oe,
   // Memory bus
   output reg [3:0] chip_sel_n,
   output reg [DW/8-1:0] byte_en_n,
   output reg [AW-1:0] mem_addr,
   output reg row_strobe_n,
   output reg col_strobe_n,
   output reg wr_enable_n,
   output reg mem_clk_enable,
   output reg extra_out_enable,
   output reg periph_xfer_strobe,
   output reg bus_oe,
   input wire [DW-1:0] mem_data_in,
   output reg [DW-1:0] mem_data_out,
   output reg mem_data_oe,
   // Hold handshake
   input wire hold_req_n,
   output reg bus_hold_ack_n
);
   localparam S_IDLE = 3'h0;
   localparam S_RDWAIT = 3'h1;
   localparam S_SELF = 3'h2;
   localparam S_FLOAT = 3'h3;
   localparam S_HELD = 3'h4;
   localparam S_DRIVE = 3'h5;
   localparam S_UNACK = 3'h6;

   reg [3:0] div_q;
   reg tick_q;
   reg hold_s1_q;
   reg hold_s2_q;
   reg [2:0] state_q;
   reg [2:0] cnt_q;
   reg rd_pdt_q;
   reg rd_start_q;
   reg wr_pdt_q;
   wire rd_pdt_out;
   wire wr_pdt_out;
   wire hold_want;
   wire go;
   wire [3:0] cmd_code;

   // Command encoder for chip select plus strobes
   function [3:0] enc;
      input [2:0] op;
      begin
         case (op)
            `OP_READ: enc = `CMD_READ;
            `OP_WRITE: enc = `CMD_WRITE;
            `OP_ROW_ACTIVATE_CMD: enc = `CMD_ROW_ACTIVATE_CMD;
            `OP_PRECHARGE_ALL_CMD: enc = `CMD_PRE;
            `OP_BANK_DEACTIVATE_CMD: enc = `CMD_PRE;
            `OP_AUTO_REFRESH_CMD: enc = `CMD_AUTO_REFRESH_CMD;
            `OP_MRS: enc = `CMD_MRS;
            default: enc = `CMD_SELF;
         endcase
      end
   endfunction

   // Interface clock divider and period tick
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= 4'h0;
         tick_q <= 1'b0;
         mem_clk_out <= 1'b0;
      end else begin
         tick_q <= 1'b0;
         if (div_q == `CLK_HALF_DIV) begin
            div_q <= 4'h0;
            mem_clk_out <= ~mem_clk_out;
            tick_q <= mem_clk_out;
         end else begin
            div_q <= div_q + 4'h1;
         end
      end
   end

   // Two-stage synchroniser on hold request
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hold_s1_q <= 1'b1;
         hold_s2_q <= 1'b1;
      end else begin
         hold_s1_q <= hold_req_n;
         hold_s2_q <= hold_s1_q;
      end
   end

   assign hold_want = ~hold_s2_q & ~hold_disable;
   assign go = tick_q & cmd_valid & cmd_ready;
   assign cmd_code = enc(cmd_op);

   // Transfer strobe delay lines
   sdram_cmd_pipe rd_pipe (
      .clock(clock),
      .rst_n(rst_n),
      .step(tick_q),
      .strobe_in(rd_pdt_q),
      .latency(xfer_read_latency),
      .strobe_out(rd_pdt_out)
   );
   sdram_cmd_pipe wr_pipe (
      .clock(clock),
      .rst_n(rst_n),
      .step(tick_q),
      .strobe_in(wr_pdt_q),
      .latency(xfer_write_latency),
      .strobe_out(wr_pdt_out)
   );

   // Command sequencer and hold handshake
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= S_IDLE;
         cnt_q <= 3'h0;
         cmd_ready <= 1'b0;
         rd_data <= {DW{1'b0}};
         rd_valid <= 1'b0;
         chip_sel_n <= 4'hf;
         byte_en_n <= {DW/8{1'b1}};
         mem_addr <= {AW{1'b0}};
         row_strobe_n <= 1'b1;
         col_strobe_n <= 1'b1;
         wr_enable_n <= 1'b1;
         mem_clk_enable <= 1'b1;
         extra_out_enable <= 1'b1;
         periph_xfer_strobe <= 1'b0;
         bus_oe <= 1'b1;
         mem_clk_oe <= 1'b1;
         mem_data_out <= {DW{1'b0}};
         mem_data_oe <= 1'b0;
         bus_hold_ack_n <= 1'b1;
         rd_pdt_q <= 1'b0;
         rd_start_q <= 1'b0;
         wr_pdt_q <= 1'b0;
      end else begin
         rd_valid <= 1'b0;
         periph_xfer_strobe <= bus_oe & (rd_pdt_out | wr_pdt_out);
         if (tick_q) begin
            // Commands last one interface period
            chip_sel_n <= 4'hf;
            row_strobe_n <= 1'b1;
            col_strobe_n <= 1'b1;
            wr_enable_n <= 1'b1;
            byte_en_n <= {DW/8{1'b1}};
            mem_data_oe <= 1'b0;
            rd_pdt_q <= 1'b0;
            wr_pdt_q <= 1'b0;
         end
         case (state_q)
            S_IDLE: begin
               cmd_ready <= ~hold_want;
               if (tick_q && hold_want) begin
                  // Nothing pending: start float countdown
                  cmd_ready <= 1'b0;
                  cnt_q <= `HOLD_FLOAT_DELAY;
                  state_q <= S_FLOAT;
               end else if (go) begin
                  chip_sel_n <= ~cmd_cs;
                  row_strobe_n <= cmd_code[2];
                  col_strobe_n <= cmd_code[1];
                  wr_enable_n <= cmd_code[0];
                  mem_addr <= cmd_addr;
                  if (cmd_op == `OP_PRECHARGE_ALL_CMD) begin
                     mem_addr[`PRE_ALL_BIT] <= 1'b1;
                  end
                  if (cmd_op == `OP_BANK_DEACTIVATE_CMD) begin
                     mem_addr[`PRE_ALL_BIT] <= 1'b0;
                  end
                  if (cmd_op == `OP_READ) begin
                     byte_en_n <= ~cmd_be;
                     cnt_q <= `CAS_LATENCY - 3'h1;
                     rd_start_q <= xfer_src_enable;
                     cmd_ready <= 1'b0;
                     state_q <= S_RDWAIT;
                  end
                  if (cmd_op == `OP_WRITE) begin
                     byte_en_n <= ~cmd_be;
                     mem_data_out <= cmd_wdata;
                     mem_data_oe <= ~xfer_dst_enable;
                     wr_pdt_q <= xfer_dst_enable;
                  end
                  if (cmd_op == `OP_SELF) begin
                     if (WIDE != 0) begin
                        mem_clk_enable <= 1'b0;
                        cmd_ready <= 1'b0;
                        state_q <= S_SELF;
                     end else begin
                        chip_sel_n <= 4'hf;
                     end
                  end
               end
            end
            S_RDWAIT: begin
               if (tick_q) begin
                  if (cnt_q == 3'h0) begin
                     rd_pdt_q <= rd_start_q;
                     if (!rd_start_q) begin
                        rd_data <= mem_data_in;
                        rd_valid <= 1'b1;
                     end
                     state_q <= S_IDLE;
                  end else begin
                     cnt_q <= cnt_q - 3'h1;
                  end
               end
            end
            S_SELF: begin
               if (tick_q && self_exit) begin
                  mem_clk_enable <= 1'b1;
                  state_q <= S_IDLE;
               end
            end
            S_FLOAT: begin
               if (tick_q) begin
                  if (cnt_q == 3'h1) begin
                     bus_oe <= 1'b0;
                     mem_clk_oe <= ~mem_clk_float_sel;
                     cnt_q <= `HOLD_ACK_DELAY;
                     state_q <= S_HELD;
                  end else begin
                     cnt_q <= cnt_q - 3'h1;
                  end
               end
            end
            S_HELD: begin
               if (tick_q) begin
                  if (cnt_q != 3'h0) begin
                     cnt_q <= cnt_q - 3'h1;
                     if (cnt_q == 3'h1) begin
                        bus_hold_ack_n <= 1'b0;
                     end
                  end else if (hold_s2_q) begin
                     cnt_q <= `HOLD_DRIVE_DELAY;
                     state_q <= S_DRIVE;
                  end
               end
            end
            S_DRIVE: begin
               if (tick_q) begin
                  if (cnt_q == 3'h1) begin
                     bus_oe <= 1'b1;
                     mem_clk_oe <= 1'b1;
                     state_q <= S_UNACK;
                  end else begin
                     cnt_q <= cnt_q - 3'h1;
                  end
               end
            end
            S_UNACK: begin
               if (tick_q) begin
                  bus_hold_ack_n <= 1'b1;
                  state_q <= S_IDLE;
               end
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end
endmodule

/* File: inc/sdram_port_map.vh */
`ifndef SDRAM_PORT_MAP_VH
`define SDRAM_PORT_MAP_VH
// Command codes {cs_n, ras_n, cas_n, we_n}
`define CMD_NOP 4'h7
`define CMD_ROW_ACTIVATE_CMD 4'h3
`define CMD_READ 4'h5
`define CMD_WRITE 4'h4
`define CMD_PRE 4'h2
`define CMD_AUTO_REFRESH_CMD 4'h1
`define CMD_MRS 4'h0
`define CMD_SELF 4'h1
// Command selectors on cmd_op
`define OP_READ 3'h0
`define OP_WRITE 3'h1
`define OP_ROW_ACTIVATE_CMD 3'h2
`define OP_PRECHARGE_ALL_CMD 3'h3
`define OP_BANK_DEACTIVATE_CMD 3'h4
`define OP_AUTO_REFRESH_CMD 3'h5
`define OP_MRS 3'h6
`define OP_SELF 3'h7
// Address bit that selects all banks on precharge
`define PRE_ALL_BIT 10
// Column latency in interface clocks
`define CAS_LATENCY 3'h3
// Interface clock divider: 100 MHz / 16 gives a 160 ns memory clock
`define CLK_HALF_DIV 4'h7
// Hold timing in interface clock periods
`define HOLD_FLOAT_DELAY 3'h2
`define HOLD_ACK_DELAY 3'h1
`define HOLD_DRIVE_DELAY 3'h3
// Reset values
`define RST_CTRL 1'b0
`endif

/* File: logic/sdram_cmd_pipe.v */
`timescale 1ns/10ps
// Delays a strobe by 0 to 3 interface clock periods
module sdram_cmd_pipe (
   // Clock and reset
   input wire clock,
   input wire rst_n,
   input wire step,
   // Strobe
   input wire strobe_in,
   input wire [1:0] latency,
   output wire strobe_out
);
   reg [2:0] pipe_q;
   wire [3:0] taps;

   // Tap 0 is the live strobe, tap n lags it by n periods
   assign taps = {pipe_q, strobe_in};

   // Shift one stage per interface period
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pipe_q <= 3'h0;
      end else if (step) begin
         pipe_q <= taps[2:0];
      end
   end

   assign strobe_out = taps[latency];
endmodule

/* File: sim/hold_port_checker.sv */
`timescale 1ns/10ps
module hold_port_checker (
   // Clock and reset
   input wire clock,
   input wire rst_n,
   // Watched ports
   input wire hold_req_n,
   input wire hold_disable,
   input wire mem_clk_float_sel,
   input wire mem_clk_oe,
   input wire mem_clk_enable,
   input wire cmd_ready,
   input wire bus_oe,
   input wire mem_data_oe,
   input wire bus_hold_ack_n
);
   reg [7:0] rel_q;
   // Clocks since the hold request went inactive
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) rel_q <= 8'h00;
      else if (!hold_req_n) rel_q <= 8'h00;
      else if (rel_q != 8'hff) rel_q <= rel_q + 8'h01;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   property p_order; $fell(bus_hold_ack_n) |-> !bus_oe; endproperty
   a_order: assert property (p_order) else $error("ack before float");
   property p_ack; $fell(bus_oe) |-> ##[1:32] !bus_hold_ack_n; endproperty
   a_ack: assert property (p_ack) else $error("ack late");
   property p_hold_disable; hold_disable && bus_hold_ack_n |=> bus_hold_ack_n; endproperty
   a_hold_disable: assert property (p_hold_disable) else $error("hold granted");
   property p_drive; $rose(bus_oe) |-> rel_q >= 8'h20 && rel_q <= 8'h70; endproperty
   a_drive: assert property (p_drive) else $error("drive window");
   property p_unack; $rose(bus_oe) |-> ##[0:32] bus_hold_ack_n; endproperty
   a_unack: assert property (p_unack) else $error("ack stuck");
   property p_ckz; mem_clk_float_sel |-> mem_clk_oe == bus_oe; endproperty
   a_ckz: assert property (p_ckz) else $error("clock driven");
   property p_ckon; !mem_clk_float_sel |-> mem_clk_oe; endproperty
   a_ckon: assert property (p_ckon) else $error("clock floated");
   property p_float; !bus_hold_ack_n && !hold_req_n |-> !bus_oe && !mem_data_oe; endproperty
   a_float: assert property (p_float) else $error("bus driven");
   property p_sync; $fell(hold_req_n) && bus_oe |-> bus_oe[*3]; endproperty
   a_sync: assert property (p_sync) else $error("float too soon");
   property p_self; !mem_clk_enable |-> !cmd_ready; endproperty
   a_self: assert property (p_self) else $error("ready in self");
endmodule
bind sdram_hold_port hold_port_checker i_chk (.clock(clock), .rst_n(rst_n),
   .hold_req_n(hold_req_n), .hold_disable(hold_disable), .mem_clk_oe(mem_clk_oe),
   .mem_clk_float_sel(mem_clk_float_sel), .mem_clk_enable(mem_clk_enable),
   .cmd_ready(cmd_ready), .bus_oe(bus_oe), .mem_data_oe(mem_data_oe),
   .bus_hold_ack_n(bus_hold_ack_n));

/* File: sim/sdram_model.sv */
`timescale 1ns/10ps
module sdram_model (
   // Memory pins
   input wire mem_clk_out,
   input wire [3:0] chip_sel_n,
   input wire row_strobe_n,
   input wire col_strobe_n,
   input wire wr_enable_n,
   input wire [19:0] mem_addr,
   output reg [15:0] mem_data_in
);
   reg [2:0] rd_q = 3'h0;
   reg [15:0] addr_q = 16'h0000;
   wire is_rd = {chip_sel_n[0], row_strobe_n, col_strobe_n, wr_enable_n} == 4'h5;
   initial mem_data_in = 16'h0000;
   // Data three memory clocks after a read, else a toggling pattern
   always @(posedge mem_clk_out) begin
      rd_q <= {rd_q[1:0], is_rd};
      if (is_rd) addr_q <= mem_addr[15:0];
      #3 mem_data_in <= rd_q[2] ? addr_q ^ 16'ha5c3 : ~mem_data_in;
   end
endmodule

/* File: sim/ext_mem_sdram_hold_port_test.sv */
`timescale 1ns/10ps
module ext_mem_sdram_hold_port_test;
   reg clock = 1'b0;
   reg rst_n = 1'b0, cmd_valid = 1'b0, xfer_src_enable = 1'b0, xfer_dst_enable = 1'b0;
   reg self_exit = 1'b0, hold_disable = 1'b0, mem_clk_float_sel = 1'b0, hold_req_n = 1'b1;
   reg [2:0] cmd_op = 3'h0;
   reg [3:0] cmd_cs = 4'h1;
   reg [19:0] cmd_addr = 20'h00000;
   reg [15:0] cmd_wdata = 16'h0000, seed = 16'h221a;
   reg [1:0] cmd_be = 2'h3, xfer_read_latency = 2'h0, xfer_write_latency = 2'h0;
   wire cmd_ready, rd_valid, mem_clk_out, mem_clk_oe, row_strobe_n, col_strobe_n, wr_enable_n;
   wire mem_clk_enable, extra_out_enable, periph_xfer_strobe, bus_oe, mem_data_oe, bus_hold_ack_n;
   wire [15:0] rd_data, mem_data_in, mem_data_out;
   wire [3:0] chip_sel_n;
   wire [1:0] byte_en_n;
   wire [19:0] mem_addr;
   wire nar_ready, nar_cke;
   reg [3:0] code;
   reg a10, cs_seen = 1'b0, pdt_seen = 1'b0, oe_seen = 1'b0;
   integer err_total = 0, check_count = 0, cyc = 0, t_cmd = 0, t_pdt = 0, t_rd = 0, i, n;
   reg [15:0] exp_q [$];
   sdram_hold_port #(.WIDE(1), .DW(16), .AW(20)) i_sdram_hold_port (
      .clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_cs(cmd_cs),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_be(cmd_be),
      .xfer_src_enable(xfer_src_enable), .xfer_dst_enable(xfer_dst_enable),
      .self_exit(self_exit), .cmd_ready(cmd_ready), .rd_data(rd_data), .rd_valid(rd_valid),
      .xfer_read_latency(xfer_read_latency), .xfer_write_latency(xfer_write_latency),
      .hold_disable(hold_disable), .mem_clk_float_sel(mem_clk_float_sel),
      .mem_clk_out(mem_clk_out), .mem_clk_oe(mem_clk_oe), .chip_sel_n(chip_sel_n),
      .byte_en_n(byte_en_n), .mem_addr(mem_addr), .row_strobe_n(row_strobe_n),
      .col_strobe_n(col_strobe_n), .wr_enable_n(wr_enable_n), .mem_clk_enable(mem_clk_enable),
      .extra_out_enable(extra_out_enable), .periph_xfer_strobe(periph_xfer_strobe),
      .bus_oe(bus_oe), .mem_data_in(mem_data_in), .mem_data_out(mem_data_out),
      .mem_data_oe(mem_data_oe), .hold_req_n(hold_req_n), .bus_hold_ack_n(bus_hold_ack_n));
   // Narrow port on the same stimulus: self refresh must be ignored there
   sdram_hold_port #(.WIDE(0), .DW(16), .AW(20)) i_sdram_hold_port_narrow (
      .clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_cs(cmd_cs),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_be(cmd_be),
      .xfer_src_enable(xfer_src_enable), .xfer_dst_enable(xfer_dst_enable),
      .self_exit(self_exit), .cmd_ready(nar_ready), .rd_data(), .rd_valid(),
      .xfer_read_latency(xfer_read_latency), .xfer_write_latency(xfer_write_latency),
      .hold_disable(hold_disable), .mem_clk_float_sel(mem_clk_float_sel),
      .mem_clk_out(), .mem_clk_oe(), .chip_sel_n(), .byte_en_n(), .mem_addr(),
      .row_strobe_n(), .col_strobe_n(), .wr_enable_n(), .mem_clk_enable(nar_cke),
      .extra_out_enable(), .periph_xfer_strobe(), .bus_oe(), .mem_data_in(mem_data_in),
      .mem_data_out(), .mem_data_oe(), .hold_req_n(hold_req_n), .bus_hold_ack_n());
   sdram_model i_sdram_model (.mem_clk_out(mem_clk_out), .chip_sel_n(chip_sel_n),
      .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n), .wr_enable_n(wr_enable_n),
      .mem_addr(mem_addr), .mem_data_in(mem_data_in));
   always #5 clock = ~clock;
   function [15:0] lfsr(input [15:0] s);
      lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task summarize;
      begin
         $display("checks %0d errors %0d", check_count, err_total);
         if (err_total == 0 && check_count > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // Pin monitor, read data check and timeout
   always @(posedge clock) begin
      cyc = cyc + 1;
      if (cyc > 20000) begin
         err_total = err_total + 1;
         summarize;
      end
      if (chip_sel_n[0] === 1'b0 && !cs_seen) begin
         code = {chip_sel_n[0], row_strobe_n, col_strobe_n, wr_enable_n};
         a10 = mem_addr[10];
         t_cmd = cyc;
      end
      cs_seen = chip_sel_n[0] === 1'b0;
      if (periph_xfer_strobe === 1'b1 && !pdt_seen) t_pdt = cyc;
      pdt_seen = periph_xfer_strobe === 1'b1;
      if (mem_data_oe === 1'b1) oe_seen = 1'b1;
      if (rd_valid === 1'b1) begin
         t_rd = cyc;
         chk(rd_data, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
      end
   end
   // One command: wait ready, offer, release when taken, let results land
   task issue(input [2:0] op, input s, input d, input [1:0] lat);
      begin
         n = 0;
         while (cmd_ready !== 1'b1 && n < 300) begin
            @(posedge clock);
            n = n + 1;
         end
         seed = lfsr(seed);
         cmd_op <= op;
         cmd_addr <= {4'h0, seed};
         cmd_wdata <= ~seed;
         xfer_src_enable <= s;
         xfer_dst_enable <= d;
         xfer_read_latency <= lat;
         xfer_write_latency <= lat;
         cmd_valid <= 1'b1;
         if (op == 3'h0 && !s) exp_q.push_back(seed ^ 16'ha5c3);
         n = 0;
         @(posedge clock);
         while (cmd_ready === 1'b1 && n < 15) begin
            @(posedge clock);
            n = n + 1;
         end
         cmd_valid <= 1'b0;
         repeat (140) @(posedge clock);
      end
   endtask
   task wait_ack(input v);
      begin
         n = 0;
         while (bus_hold_ack_n !== v && n < 200) begin
            @(posedge clock);
            n = n + 1;
         end
         chk(bus_hold_ack_n, v);
      end
   endtask
   initial begin
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      for (i = 1; i < 7; i = i + 1) begin
         issue(i[2:0], 1'b0, 1'b0, 2'h0);
         chk(code, (28'h0122345 >> (i * 4)) & 4'hf);
         if (i == 3 || i == 4) chk(a10, i == 3);
      end
      for (i = 0; i < 3; i = i + 1) begin
         issue(3'h0, 1'b0, 1'b0, 2'h0);
         chk(code, 4'h5);
         chk((t_rd - t_cmd + 8) / 16, 3);
      end
      for (i = 0; i < 4; i = i + 1) begin
         t_rd = 0;
         t_pdt = 0;
         issue(3'h0, 1'b1, 1'b0, i[1:0]);
         chk((t_pdt - t_cmd + 8) / 16, 3 + i);
         chk(t_rd, 0);
         oe_seen = 1'b0;
         t_pdt = 0;
         issue(3'h1, 1'b0, 1'b1, i[1:0]);
         chk((t_pdt - t_cmd + 8) / 16, i);
         chk(oe_seen, 0);
      end
      oe_seen = 1'b0;
      t_pdt = 0;
      issue(3'h1, 1'b0, 1'b0, 2'h0);
      chk(oe_seen, 1);
      chk(t_pdt, 0);
      chk(mem_data_out, seed ^ 16'hffff);
      for (i = 0; i < 2; i = i + 1) begin
         mem_clk_float_sel <= i[0];
         hold_disable <= 1'b1;
         hold_req_n <= 1'b0;
         repeat (100) @(posedge clock);
         chk(bus_hold_ack_n, 1);
         hold_disable <= 1'b0;
         wait_ack(1'b0);
         chk(bus_oe, 0);
         chk(mem_clk_oe, !i[0]);
         repeat (20) @(posedge clock);
         hold_req_n <= 1'b1;
         wait_ack(1'b1);
         chk(bus_oe, 1);
      end
      issue(3'h7, 1'b0, 1'b0, 2'h0);
      chk(code, 4'h1);
      chk(mem_clk_enable, 0);
      chk(nar_cke, 1);
      chk(nar_ready, 1);
      self_exit <= 1'b1;
      n = 0;
      while (mem_clk_enable !== 1'b1 && n < 300) begin
         @(posedge clock);
         n = n + 1;
      end
      chk(mem_clk_enable, 1);
      chk(exp_q.size(), 0);
      summarize;
   end
endmodule
